// file: logic/pfd_map.svh
// register indices, field positions, reset values and codes of the
// pll status and fine delay register slice
// assumes APB byte addresses are four times the register index
`ifndef PFD_MAP_SVH
`define PFD_MAP_SVH

// register indices (byte address = index * 4)
`define PFD_IDX_THR 10'h01a
`define PFD_IDX_STATUS 10'h01f
`define PFD_IDX_BYPASS 10'h0a0
`define PFD_IDX_RAMP 10'h0a1
`define PFD_IDX_IRQ_ST 10'h0f0
`define PFD_IDX_IRQ_MASK 10'h0f1

// field positions
`define PFD_THR_BIT 6
`define PFD_BYP_BIT 0
`define PFD_CAP_HI 5
`define PFD_CAP_LO 3
`define PFD_CUR_HI 2
`define PFD_CUR_LO 0

// reset values
`define PFD_RST_THR 8'h00
`define PFD_RST_BYPASS 8'h01
`define PFD_RST_RAMP 8'h00
`define PFD_RST_IRQ 4'h0
`define PFD_RST_CAPS 3'h4
`define PFD_RST_DLY_BYP 1'b1

// capacitor counts by code
`define PFD_CAPS_4 3'h4
`define PFD_CAPS_3 3'h3
`define PFD_CAPS_2 3'h2
`define PFD_CAPS_1 3'h1

// full-scale weight per capacitor at the smallest ramp current
`define PFD_FS_PER_CAP 8'h30
// reset full scale equals four caps at the smallest current, so the
// output does not jump in the first cycle after reset
`define PFD_RST_FS 8'hc0

`endif

// file: logic/pfd_pkg.sv
// types shared by the pll status and fine delay register slice
// assumes pfd_map.svh supplies all numeric constants
package pfd_pkg;

	// monitor levels from the analog pll and reference monitors
	typedef struct packed {
		logic vco_above;
		logic second_ref_above;
		logic first_ref_above;
		logic pll_locked;
	} pfd_mon_t;

	// fine delay settings for the sixth_clock_output delay stage
	typedef struct packed {
		logic bypass;
		logic [2:0] cap_code;
		logic [2:0] cap_count;
		logic [2:0] current_sel;
		logic [7:0] full_scale;
	} pfd_dly_cfg_t;

	// apb slave phase, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACK = 2'b10
	} pfd_apb_st_t;

endpackage

// file: logic/pfd_regs.sv
// register slice: pll monitor status, reference threshold select and
// fine delay configuration of the sixth_clock_output, on APB
// assumes monitor inputs are synchronous to sys_clk
//
// Function
// RL1 - status reports 1 above the oscillator threshold, 0 below it.
// RL2 - the oscillator flag is bit 3 of read-only status register 0x01F.
// RL3 - status bit 2 is 1 when second_reference_input is above threshold.
// RL4 - status bit 1 is 1 when first_reference_input is above threshold.
// RL5 - both reference flags use the threshold picked by bit 6 of 0x01A.
// RL6 - status bit 0 shows the digital lock result, 1 locked, 0 unlocked.
// RL7 - the monitor status bits are read-only; writes do not change them.
// RL8 - bit 0 of register 0x0A0 set bypasses the fine delay stage.
// RL9 - bits 5:3 of 0x0A1 pick four, three or two ramp caps, four default; here code 7 gives one cap.
// RL10 - delay full scale follows from capacitor count and ramp current.
// RL11 - bits 2:0 of 0x0A1 hold the ramp current select of the delay.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "pfd_map.svh"

module pfd_regs (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pfd_pkg::pfd_mon_t mon_in,
	output logic ref_thr_sel,
	output pfd_pkg::pfd_dly_cfg_t dly_cfg,
	output logic irq
);
	import pfd_pkg::*;

	// byte address of a register index
	function automatic logic [11:0] pfd_addr(input logic [9:0] idx);
		pfd_addr = {idx, 2'b00};
	endfunction

	// capacitor count for a capacitor code
	function automatic logic [2:0] pfd_caps(input logic [2:0] code);
		case (code)
			3'h0: pfd_caps = `PFD_CAPS_4;
			3'h1, 3'h2, 3'h4: pfd_caps = `PFD_CAPS_3;
			3'h3, 3'h5, 3'h6: pfd_caps = `PFD_CAPS_2;
			default: pfd_caps = `PFD_CAPS_1;
		endcase
	endfunction

	// full scale grows with capacitance and shrinks with ramp current
	function automatic logic [7:0] pfd_fs(input logic [2:0] caps,
		input logic [2:0] cur);
		logic [10:0] num;
		logic [3:0] den;
		num = {8'h00, caps} * {3'h0, `PFD_FS_PER_CAP};
		den = {1'b0, cur} + 4'h1;
		pfd_fs = 8'(num / {7'h00, den});
	endfunction

	pfd_apb_st_t state_ff, nxt_state;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic [7:0] thr_ff, nxt_thr;
	logic [7:0] byp_ff, nxt_byp;
	logic [7:0] ramp_ff, nxt_ramp;
	logic [3:0] irq_st_ff, nxt_irq_st;
	logic [3:0] irq_mask_ff, nxt_irq_mask;
	logic irq_ff, nxt_irq;
	pfd_mon_t mon_ff, nxt_mon;
	pfd_dly_cfg_t dly_ff, nxt_dly;
	logic ref_thr_ff, nxt_ref_thr;
	logic hit;
	logic [31:0] rd_val;
	logic wr_fire;
	logic [3:0] mon_ev;

	// address decode and read mux on the address held by the master
	always_comb begin
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		if (paddr == pfd_addr(`PFD_IDX_THR)) begin
			rd_val = {24'h00_0000, thr_ff};
		end else if (paddr == pfd_addr(`PFD_IDX_STATUS)) begin
			rd_val = {28'h000_0000, mon_ff}; // RL2 RL3 RL4 RL6
		end else if (paddr == pfd_addr(`PFD_IDX_BYPASS)) begin
			rd_val = {24'h00_0000, byp_ff};
		end else if (paddr == pfd_addr(`PFD_IDX_RAMP)) begin
			rd_val = {24'h00_0000, ramp_ff};
		end else if (paddr == pfd_addr(`PFD_IDX_IRQ_ST)) begin
			rd_val = {28'h000_0000, irq_st_ff};
		end else if (paddr == pfd_addr(`PFD_IDX_IRQ_MASK)) begin
			rd_val = {28'h000_0000, irq_mask_ff};
		end else begin
			hit = 1'b0;
		end
	end

	// apb phase: answer one cycle after setup so that every bus output
	// comes from a flip-flop, still with no wait state in the access phase
	always_comb begin
		nxt_state = state_ff;
		nxt_prdata = prdata_ff;
		nxt_pready = 1'b0;
		nxt_pslverr = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (psel && !penable) begin
					nxt_state = ST_ACK;
					nxt_pready = 1'b1;
					nxt_prdata = pwrite ? 32'h0000_0000 : rd_val;
					nxt_pslverr = !hit;
				end
			end
			ST_ACK: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	assign wr_fire = (state_ff == ST_ACK) && psel && penable && pwrite;

	// writable registers; the status register has no write path
	always_comb begin
		nxt_thr = thr_ff;
		nxt_byp = byp_ff;
		nxt_ramp = ramp_ff;
		nxt_irq_mask = irq_mask_ff;
		if (wr_fire) begin
			if (paddr == pfd_addr(`PFD_IDX_THR)) begin
				nxt_thr = pwdata[7:0];
			end else if (paddr == pfd_addr(`PFD_IDX_BYPASS)) begin
				nxt_byp = pwdata[7:0]; // RL8
			end else if (paddr == pfd_addr(`PFD_IDX_RAMP)) begin
				nxt_ramp = pwdata[7:0]; // RL9 RL11
			end else if (paddr == pfd_addr(`PFD_IDX_IRQ_MASK)) begin
				nxt_irq_mask = pwdata[3:0];
			end
		end
	end

	// monitor sampling; a status write never reaches these flops
	always_comb begin
		nxt_mon = mon_in; // RL1 RL3 RL4 RL6 RL7
		nxt_ref_thr = thr_ff[`PFD_THR_BIT]; // RL5
	end

	// any change of a monitor level is an event; set beats clear
	assign mon_ev = mon_in ^ mon_ff;
	always_comb begin
		nxt_irq_st = irq_st_ff;
		if (wr_fire && paddr == pfd_addr(`PFD_IDX_IRQ_ST)) begin
			nxt_irq_st = irq_st_ff & ~pwdata[3:0];
		end
		nxt_irq_st = nxt_irq_st | mon_ev;
		nxt_irq = |(irq_st_ff & irq_mask_ff);
	end

	// delay stage settings decoded from the configuration registers
	always_comb begin
		nxt_dly.bypass = byp_ff[`PFD_BYP_BIT]; // RL8
		nxt_dly.cap_code = ramp_ff[`PFD_CAP_HI:`PFD_CAP_LO];
		nxt_dly.cap_count = pfd_caps(ramp_ff[`PFD_CAP_HI:`PFD_CAP_LO]); // RL9
		nxt_dly.current_sel = ramp_ff[`PFD_CUR_HI:`PFD_CUR_LO]; // RL11
		nxt_dly.full_scale = pfd_fs(
			pfd_caps(ramp_ff[`PFD_CAP_HI:`PFD_CAP_LO]),
			ramp_ff[`PFD_CUR_HI:`PFD_CUR_LO]); // RL10
	end

	// all state registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_ff <= ST_IDLE;
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			thr_ff <= `PFD_RST_THR;
			byp_ff <= `PFD_RST_BYPASS;
			ramp_ff <= `PFD_RST_RAMP;
			irq_st_ff <= `PFD_RST_IRQ;
			irq_mask_ff <= `PFD_RST_IRQ;
			irq_ff <= 1'b0;
			mon_ff <= '0;
			ref_thr_ff <= 1'b0;
			dly_ff.bypass <= `PFD_RST_DLY_BYP;
			dly_ff.cap_code <= 3'h0;
			dly_ff.cap_count <= `PFD_RST_CAPS;
			dly_ff.current_sel <= 3'h0;
			dly_ff.full_scale <= `PFD_RST_FS;
		end else begin
			state_ff <= nxt_state;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			thr_ff <= nxt_thr;
			byp_ff <= nxt_byp;
			ramp_ff <= nxt_ramp;
			irq_st_ff <= nxt_irq_st;
			irq_mask_ff <= nxt_irq_mask;
			irq_ff <= nxt_irq;
			mon_ff <= nxt_mon;
			ref_thr_ff <= nxt_ref_thr;
			dly_ff <= nxt_dly;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign ref_thr_sel = ref_thr_ff;
	assign dly_cfg = dly_ff;
	assign irq = irq_ff;

	// a read setup of the status register
	sequence s_stat_rd;
		state_ff == ST_IDLE && psel && !penable && !pwrite &&
			paddr == pfd_addr(`PFD_IDX_STATUS);
	endsequence

	// a completed write to a given register index
	sequence s_wr(logic [9:0] idx);
		wr_fire && paddr == pfd_addr(idx);
	endsequence

	property p_vco_follow;
		@(posedge sys_clk) disable iff (srst)
		##1 mon_ff.vco_above == $past(mon_in.vco_above);
	endproperty
	a_vco_follow: assert property (p_vco_follow) // RL1
		else $error("vco flag does not follow its monitor");

	property p_vco_bit3;
		@(posedge sys_clk) disable iff (srst)
		s_stat_rd |=> pready && prdata[3] == $past(mon_ff.vco_above)
			&& prdata[31:4] == 28'h000_0000;
	endproperty
	a_vco_bit3: assert property (p_vco_bit3) // RL2
		else $error("status bit 3 is not the vco flag");

	property p_second_reference_input_bit2;
		@(posedge sys_clk) disable iff (srst)
		s_stat_rd |=> prdata[2] == $past(mon_ff.second_ref_above);
	endproperty
	a_second_reference_input_bit2: assert property (p_second_reference_input_bit2) // RL3
		else $error("status bit 2 is not the second reference flag");

	property p_first_reference_input_bit1;
		@(posedge sys_clk) disable iff (srst)
		s_stat_rd |=> prdata[1] == $past(mon_ff.first_ref_above);
	endproperty
	a_first_reference_input_bit1: assert property (p_first_reference_input_bit1) // RL4
		else $error("status bit 1 is not the first reference flag");

	property p_thr_sel;
		@(posedge sys_clk) disable iff (srst)
		s_wr(`PFD_IDX_THR) |=> ##1 ref_thr_sel == $past(pwdata[6], 2);
	endproperty
	a_thr_sel: assert property (p_thr_sel) // RL5
		else $error("threshold select does not follow bit 6");

	property p_lock_bit0;
		@(posedge sys_clk) disable iff (srst)
		s_stat_rd |=> prdata[0] == $past(mon_in.pll_locked, 2);
	endproperty
	a_lock_bit0: assert property (p_lock_bit0) // RL6
		else $error("status bit 0 is not the lock result");

	property p_stat_ro;
		@(posedge sys_clk) disable iff (srst)
		s_wr(`PFD_IDX_STATUS) |-> !pslverr ##1 mon_ff == $past(mon_in);
	endproperty
	a_stat_ro: assert property (p_stat_ro) // RL7
		else $error("status write disturbed the monitor flags");

	property p_bypass;
		@(posedge sys_clk) disable iff (srst)
		s_wr(`PFD_IDX_BYPASS) |=> ##1 dly_cfg.bypass == $past(pwdata[0], 2);
	endproperty
	a_bypass: assert property (p_bypass) // RL8
		else $error("bypass output does not follow register 0x0a0");

	property p_caps;
		@(posedge sys_clk) disable iff (srst)
		s_wr(`PFD_IDX_RAMP) ##1 1'b1 |=>
			dly_cfg.cap_count == pfd_caps($past(pwdata[5:3], 2));
	endproperty
	a_caps: assert property (p_caps) // RL9
		else $error("capacitor count wrong for its code");

	property p_full_scale;
		@(posedge sys_clk) disable iff (srst)
		##1 dly_cfg.full_scale == pfd_fs(pfd_caps($past(ramp_ff[5:3])),
			$past(ramp_ff[2:0]));
	endproperty
	a_full_scale: assert property (p_full_scale) // RL10
		else $error("full scale does not match capacitors and current");

	property p_current;
		@(posedge sys_clk) disable iff (srst)
		s_wr(`PFD_IDX_RAMP) |=> ##1
			dly_cfg.current_sel == $past(pwdata[2:0], 2);
	endproperty
	a_current: assert property (p_current) // RL11
		else $error("ramp current select does not follow register");

	property p_irq;
		@(posedge sys_clk) disable iff (srst)
		(mon_in != mon_ff) ##1 (irq_mask_ff != 4'h0 &&
			(irq_st_ff & irq_mask_ff) != 4'h0) |=> irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("unmasked event did not raise the interrupt");

endmodule

// file: testbench/pfd_regs_tb.sv
// self-checking bench of the pll status and fine delay register slice
// assumes pfd_regs answers every apb access with one wait-free cycle
`timescale 1ns/1ps
`include "pfd_map.svh"

module pfd_regs_tb;
	import pfd_pkg::*;

	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ref_thr_sel;
	logic irq;
	pfd_mon_t mon_in = 4'h0;
	pfd_dly_cfg_t dly_cfg;
	logic [31:0] rd;
	logic er;
	logic [2:0] cur;
	int fail_count = 0;
	int num_checks = 0;
	int seed = 29362;
	int i;

	pfd_regs dut (
		.sys_clk(sys_clk),
		.srst(srst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.mon_in(mon_in),
		.ref_thr_sel(ref_thr_sel),
		.dly_cfg(dly_cfg),
		.irq(irq)
	);

	// 25 mhz system clock
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one apb transfer; the wait for pready is bounded so a hang ends
	task automatic apb(input logic w, input logic [9:0] idx,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			tally_and_finish;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [9:0] idx,
		input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(nm, rd, exp);
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// capacitor count expected for a code
	function automatic logic [2:0] caps(input logic [2:0] c);
		case (c)
			3'h0: caps = 3'h4;
			3'h1, 3'h2, 3'h4: caps = 3'h3;
			3'h3, 3'h5, 3'h6: caps = 3'h2;
			default: caps = 3'h1;
		endcase
	endfunction

	// full scale in relative units: count times 48 over current step
	function automatic logic [7:0] fs(input logic [2:0] c, input logic [2:0] s);
		fs = 8'((32'(caps(c)) * 48) / (32'(s) + 1));
	endfunction

	initial begin
		ticks(3);
		srst <= 1'b0;
		rchk("bypass_reset", `PFD_IDX_BYPASS, 32'h1);
		rchk("ramp_reset", `PFD_IDX_RAMP, 32'h0);
		chk("caps_reset", {29'h0, dly_cfg.cap_count}, 32'h4);
		// random monitor levels; status lags mon_in by one edge
		for (i = 0; i < 14; i++) begin
			@(posedge sys_clk);
			mon_in <= 4'($random(seed));
			ticks(2);
			rchk("status", `PFD_IDX_STATUS, {28'h0, mon_in});
			apb(1'b1, `PFD_IDX_STATUS, ~{28'h0, mon_in});
			chk("status_wr_err", {31'h0, er}, 32'h0);
			rchk("status_ro", `PFD_IDX_STATUS, {28'h0, mon_in});
		end
		// threshold select follows bit 6 only
		apb(1'b1, `PFD_IDX_THR, 32'h40);
		ticks(2);
		chk("thr_sel_set", {31'h0, ref_thr_sel}, 32'h1);
		apb(1'b1, `PFD_IDX_THR, 32'hbf);
		ticks(2);
		chk("thr_sel_clr", {31'h0, ref_thr_sel}, 32'h0);
		rchk("thr_back", `PFD_IDX_THR, 32'hbf);
		// every capacitor code with a random current
		for (i = 0; i < 8; i++) begin
			cur = 3'($random(seed));
			apb(1'b1, `PFD_IDX_RAMP, {26'h0, i[2:0], cur});
			ticks(3);
			chk("cap_count", {29'h0, dly_cfg.cap_count}, caps(i[2:0]));
			chk("cap_code", {29'h0, dly_cfg.cap_code}, {29'h0, i[2:0]});
			chk("current_sel", {29'h0, dly_cfg.current_sel}, cur);
			chk("full_scale", {24'h0, dly_cfg.full_scale}, fs(i[2:0], cur));
			rchk("ramp_back", `PFD_IDX_RAMP, {26'h0, i[2:0], cur});
		end
		apb(1'b1, `PFD_IDX_BYPASS, 32'h0);
		ticks(2);
		chk("bypass_off", {31'h0, dly_cfg.bypass}, 32'h0);
		apb(1'b1, `PFD_IDX_BYPASS, 32'h1);
		ticks(2);
		chk("bypass_on", {31'h0, dly_cfg.bypass}, 32'h1);
		// unmapped place: error flagged, reads zero
		apb(1'b1, 10'h055, 32'hff);
		chk("slverr_wr", {31'h0, er}, 32'h1);
		rchk("unmapped_rd", 10'h055, 32'h0);
		chk("slverr_rd", {31'h0, er}, 32'h1);
		// interrupt: raise, mask, unmask, clear
		@(posedge sys_clk);
		mon_in <= 4'h0;
		ticks(3);
		apb(1'b1, `PFD_IDX_IRQ_ST, 32'hf);
		apb(1'b1, `PFD_IDX_IRQ_MASK, 32'h1);
		ticks(2);
		chk("irq_idle", {31'h0, irq}, 32'h0);
		@(posedge sys_clk);
		mon_in.pll_locked <= 1'b1;
		ticks(3);
		chk("irq_raised", {31'h0, irq}, 32'h1);
		rchk("irq_status", `PFD_IDX_IRQ_ST, 32'h1);
		apb(1'b1, `PFD_IDX_IRQ_MASK, 32'h0);
		ticks(2);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		apb(1'b1, `PFD_IDX_IRQ_MASK, 32'h1);
		ticks(2);
		chk("irq_unmasked", {31'h0, irq}, 32'h1);
		apb(1'b1, `PFD_IDX_IRQ_ST, 32'h1);
		ticks(2);
		chk("irq_cleared", {31'h0, irq}, 32'h0);
		rchk("irq_status_clr", `PFD_IDX_IRQ_ST, 32'h0);
		tally_and_finish;
	end
endmodule
